// ==== rtl/uart_pkg.sv ====
// Function
// RULE_01: async start-stop and sync transfer both supported
// RULE_02: sync mode shifts eight data bits only
// RULE_03: mode 0 async, 1 multiproc, 2 sync
// RULE_04: multiprocessor mode is master side only
// RULE_05: multiproc frame: eight data plus address flag
// RULE_06: seven-bit words only in async normal mode
// RULE_07: send one or two stops, check one
// RULE_08: framing, overrun, parity errors; no multiproc parity
// RULE_09: receive irq on frame/error, send irq on done
// RULE_10: both requests may start hardware transfer service
// RULE_11: bit rate up to 2 MHz at 16 MHz
// RULE_12: clock from generator, serial clock pin, timer
// RULE_13: eight baud settings across all sources
// RULE_14: NRZ, level held whole bit period
// RULE_15: one holding stage per direction, full duplex
// RULE_16: reload timer 0 output clocks the port
// RULE_17: start on falling edge, sample bit centres
// RULE_18: overrun when new frame meets unread word
`default_nettype none
package uart_pkg;
	typedef enum logic [1:0] {
		mode_async = 2'b00,
		mode_multi = 2'b01,
		mode_sync = 2'b10
	} op_mode_t;

	typedef enum logic [2:0] {
		clk_gen_div2 = 3'b000,
		clk_gen_div4 = 3'b001,
		clk_gen_div8 = 3'b010,
		clk_gen_div16 = 3'b011,
		clk_gen_div32 = 3'b100,
		clk_gen_div64 = 3'b101,
		clk_ext_pin = 3'b110,
		clk_timer0 = 3'b111
	} baud_sel_t;

	typedef struct packed {
		op_mode_t mode;
		logic seven_bit;
		logic parity_en;
		logic parity_odd;
		logic two_stop;
		baud_sel_t baud;
		logic rx_en;
		logic tx_en;
	} uart_cfg_t;

	typedef struct packed {
		logic framing;
		logic overrun;
		logic parity;
	} rx_err_t;

	// 16 oversampling ticks per bit in async modes
	localparam int unsigned oversample = 16;
	localparam logic [3:0] os_last = 4'hf;
	localparam logic [3:0] os_mid = 4'h7;
	localparam logic [5:0] gen_base_div = 6'h02;
	localparam logic [3:0] bits_eight = 4'h8;
	localparam logic [3:0] bits_seven = 4'h7;

	localparam real clk_mhz = 250.0;
	localparam real max_bit_mhz = 2.0;
	// fastest legal bit period in system clocks (rounded down)
	localparam int unsigned min_bit_cycles = int'($floor(clk_mhz / max_bit_mhz));
endpackage
`default_nettype wire

// ==== rtl/uart_baud_tick.sv ====
`default_nettype none
module uart_baud_tick
	import uart_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire baud_sel_t baud,
	input wire logic ext_clk,
	input wire logic timer0_out,
	output logic tick
);
	// ----------------------------------------
	// baud tick source select
	// ----------------------------------------
	logic [11:0] div_cnt;
	logic ext_s1, ext_s2, ext_s3, tmr_s1, tmr_s2, tmr_s3;
	logic [11:0] div_end;

	// generator divides by 2^(n+1), so the slowest of six is /64 per tick
	always_comb begin
		div_end = 12'(({6'h00, gen_base_div} << baud[2:0]) - 12'h001);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt <= 12'h000;
		end else if (div_cnt >= div_end) begin
			div_cnt <= 12'h000;
		end else begin
			div_cnt <= div_cnt + 12'h001;
		end
	end

	// pins come from outside, so two flops before the edge detector
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			tmr_s1 <= 1'b0;
			tmr_s2 <= 1'b0;
			tmr_s3 <= 1'b0;
		end else begin
			ext_s1 <= ext_clk;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			tmr_s1 <= timer0_out;
			tmr_s2 <= tmr_s1;
			tmr_s3 <= tmr_s2;
		end
	end

	always_comb begin
		case (baud)
			clk_ext_pin: tick = ext_s2 & ~ext_s3; // RULE_12
			clk_timer0: tick = tmr_s2 & ~tmr_s3; // RULE_16
			default: tick = (div_cnt >= div_end); // RULE_11 RULE_13
		endcase
	end

	gen_tick_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
		(baud == clk_gen_div2 && tick) ##1 (baud == clk_gen_div2)
		##1 (baud == clk_gen_div2) |-> tick)
		else $error("fastest generator setting did not tick every second cycle");
endmodule
`default_nettype wire

// ==== rtl/uart_core.sv ====
`default_nettype none
module uart_core
	import uart_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire uart_cfg_t cfg,
	input wire logic ext_clk_in,
	input wire logic timer0_out,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic [8:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [8:0] rx_data,
	output logic rx_valid,
	input wire logic rx_read,
	output rx_err_t rx_err,
	input wire logic err_clear,
	output logic tx_irq,
	output logic rx_irq,
	output logic tx_hw_transfer_service,
	output logic rx_hw_transfer_service,
	input wire logic hw_transfer_service_en
);
	typedef enum logic [1:0] {
		tx_idle = 2'b00,
		tx_start = 2'b01,
		tx_shift = 2'b10,
		tx_stop = 2'b11
	} tx_state_t;

	typedef enum logic [1:0] {
		rx_idle = 2'b00,
		rx_start = 2'b01,
		rx_shift = 2'b10,
		rx_stop = 2'b11
	} rx_state_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [3:0] word_bits(input uart_cfg_t c);
		word_bits = (c.mode == mode_async && c.seven_bit) ? bits_seven : bits_eight; // RULE_06
	endfunction

	function automatic logic parity_on(input uart_cfg_t c);
		parity_on = (c.mode == mode_async) && c.parity_en; // RULE_02 RULE_05
	endfunction

	function automatic logic calc_par(input logic [7:0] d, input logic [3:0] n,
		input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < n) begin
				p = p ^ d[i];
			end
		end
		calc_par = p;
	endfunction

	// ----------------------------------------
	// clocking
	// ----------------------------------------
	logic tick;
	logic is_sync;
	logic rx_s1, rx_s2, rx_s3;

	assign is_sync = (cfg.mode == mode_sync); // RULE_01 RULE_03

	uart_baud_tick u_tick (
		.clk(clk),
		.sys_rst(sys_rst),
		.baud(cfg.baud),
		.ext_clk(ext_clk_in),
		.timer0_out(timer0_out),
		.tick(tick)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
		end else begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	tx_state_t tx_st;
	logic [8:0] tx_hold;
	logic tx_hold_full;
	logic [8:0] tx_sh;
	logic [3:0] tx_os, tx_cnt;
	logic tx_stop2;
	logic tx_done;
	logic tx_bit_end;
	logic [3:0] tx_total;
	logic tx_load;
	logic sclk_fall;

	// sync words start on a tick so the first bit lasts a whole bit period
	assign tx_load = (tx_st == tx_idle) && tx_hold_full && cfg.tx_en && (!is_sync || tick);
	// sync mode: one tick per bit; async: sixteen
	assign tx_bit_end = tick && (is_sync || tx_os == os_last);
	assign tx_ready = ~tx_hold_full; // RULE_15
	assign tx_total = word_bits(cfg) + {3'b000, parity_on(cfg) || cfg.mode == mode_multi};

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_hold <= 9'h000;
			tx_hold_full <= 1'b0;
		end else if (tx_valid && !tx_hold_full) begin
			tx_hold <= tx_data;
			tx_hold_full <= 1'b1; // RULE_15
		end else if (tx_load) begin
			tx_hold_full <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_st <= tx_idle;
			tx_sh <= 9'h000;
			tx_os <= 4'h0;
			tx_cnt <= 4'h0;
			tx_stop2 <= 1'b0;
			tx_pin <= 1'b1;
			tx_done <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (tick && !is_sync) begin
				tx_os <= tx_os + 4'h1;
			end
			case (tx_st)
				tx_idle: begin
					tx_pin <= 1'b1;
					tx_os <= 4'h0;
					if (tx_load) begin
						tx_sh <= tx_hold;
						// parity follows the last data bit; mode 1 keeps bit 8 as the flag
						if (parity_on(cfg)) begin
							tx_sh[word_bits(cfg)] <= calc_par(tx_hold[7:0], word_bits(cfg),
								cfg.parity_odd);
						end
						tx_cnt <= 4'h0;
						tx_st <= is_sync ? tx_shift : tx_start; // RULE_02
						tx_pin <= is_sync ? tx_hold[0] : 1'b0;
					end
				end
				tx_start: if (tx_bit_end) begin
					tx_st <= tx_shift;
					tx_pin <= tx_sh[0]; // RULE_14
				end
				tx_shift: if (tx_bit_end) begin
					if (tx_cnt == (is_sync ? bits_eight : tx_total) - 4'h1) begin
						tx_done <= is_sync;
						tx_st <= is_sync ? tx_idle : tx_stop;
						tx_stop2 <= cfg.two_stop; // RULE_07
						tx_pin <= 1'b1;
					end else begin
						tx_cnt <= tx_cnt + 4'h1;
						tx_sh <= {1'b0, tx_sh[8:1]};
						tx_pin <= tx_sh[1];
					end
				end
				tx_stop: if (tx_bit_end) begin
					if (tx_stop2) begin
						tx_stop2 <= 1'b0;
					end else begin
						tx_done <= 1'b1;
						tx_st <= tx_idle;
					end
				end
				default: tx_st <= tx_idle;
			endcase
		end
	end

	// sync shift clock falls with each new data bit and rises one clock later,
	// so the far side samples a settled line on the rising edge
	assign sclk_fall = is_sync && (tx_load || (tx_st == tx_shift && tx_bit_end
		&& tx_cnt != bits_eight - 4'h1));
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_clock_pin_out <= 1'b1;
		end else begin
			serial_clock_pin_out <= ~sclk_fall; // RULE_02
		end
	end
	assign serial_clock_pin_oe = is_sync && cfg.baud != clk_ext_pin;

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	rx_state_t rx_st;
	logic [3:0] rx_os, rx_cnt;
	logic [8:0] rx_sh;
	logic [8:0] rx_align;
	logic rx_done;
	logic rx_sample;
	logic rx_fe_now, rx_pe_now;

	assign rx_sample = tick && (is_sync || rx_os == os_mid); // RULE_17

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_st <= rx_idle;
			rx_os <= 4'h0;
			rx_cnt <= 4'h0;
			rx_sh <= 9'h000;
			rx_done <= 1'b0;
			rx_fe_now <= 1'b0;
			rx_pe_now <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (tick && !is_sync) begin
				rx_os <= rx_os + 4'h1;
			end
			case (rx_st)
				rx_idle: begin
					rx_os <= 4'h0;
					rx_cnt <= 4'h0;
					if (cfg.rx_en && !is_sync && rx_s3 && !rx_s2) begin
						rx_st <= rx_start; // RULE_17
					end else if (cfg.rx_en && is_sync && tx_load) begin
						rx_st <= rx_shift;
					end
				end
				rx_start: if (rx_sample) begin
					rx_st <= rx_s2 ? rx_idle : rx_shift;
				end
				rx_shift: if (rx_sample) begin
					rx_sh <= {rx_s2, rx_sh[8:1]};
					if (rx_cnt == (is_sync ? bits_eight : tx_total) - 4'h1) begin
						rx_st <= is_sync ? rx_idle : rx_stop;
						rx_done <= is_sync;
						rx_fe_now <= 1'b0;
						rx_pe_now <= 1'b0;
					end else begin
						rx_cnt <= rx_cnt + 4'h1;
					end
				end
				rx_stop: if (rx_sample) begin
					rx_fe_now <= ~rx_s2; // RULE_07
					rx_pe_now <= parity_on(cfg) && (calc_par(rx_align[7:0], word_bits(cfg),
						cfg.parity_odd) != rx_align[word_bits(cfg)]); // RULE_08
					rx_done <= 1'b1;
					rx_st <= rx_idle;
				end
				default: rx_st <= rx_idle;
			endcase
		end
	end

	logic [8:0] rx_word;
	always_comb begin
		rx_align = rx_sh >> (4'h9 - (is_sync ? bits_eight : tx_total));
		rx_word = rx_align;
		if (parity_on(cfg)) begin
			rx_word[word_bits(cfg)] = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_data <= 9'h000;
			rx_valid <= 1'b0;
		end else if (rx_done) begin
			if (!rx_valid || rx_read) begin
				rx_data <= rx_word; // RULE_04 RULE_15
			end
			rx_valid <= 1'b1;
		end else if (rx_read) begin
			rx_valid <= 1'b0;
		end
	end

	// set wins over clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_err <= '0;
		end else begin
			rx_err.overrun <= (rx_done && rx_valid && !rx_read) || (rx_err.overrun && !err_clear); // RULE_18
			rx_err.framing <= (rx_done && rx_fe_now) || (rx_err.framing && !err_clear); // RULE_08
			rx_err.parity <= (rx_done && rx_pe_now) || (rx_err.parity && !err_clear); // RULE_08
		end
	end

	// ----------------------------------------
	// requests
	// ----------------------------------------
	assign rx_irq = rx_valid || (|rx_err); // RULE_09
	assign rx_hw_transfer_service = rx_valid && hw_transfer_service_en; // RULE_10
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_irq <= 1'b0;
		end else begin
			tx_irq <= tx_done || (tx_irq && !tx_valid); // RULE_09
		end
	end
	assign tx_hw_transfer_service = tx_irq && hw_transfer_service_en; // RULE_10

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sync_no_start_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
		(is_sync && tx_load) |=> tx_st == tx_shift)
		else $error("sync transfer inserted a start bit");
	start_low_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
		(tx_st == tx_start) |-> !tx_pin)
		else $error("start bit not low");
	stop_high_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
		(tx_st == tx_stop) |-> tx_pin)
		else $error("stop bit not high");
	overrun_set_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_18
		(rx_done && rx_valid && !rx_read) |=> rx_err.overrun)
		else $error("overrun not flagged");
	multi_no_par_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
		(cfg.mode == mode_multi && $stable(cfg.mode) && rx_done) |=> !$rose(rx_err.parity))
		else $error("parity error in multiprocessor mode");
	rx_irq_set_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
		rx_done |=> rx_irq)
		else $error("receive request missing");
	tx_irq_set_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
		tx_done |=> tx_irq)
		else $error("send request missing");
	hold_stall_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
		(tx_hold_full && tx_st != tx_idle) |=> !tx_ready)
		else $error("holding stage accepted while busy");
	svc_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
		(tx_done && hw_transfer_service_en) |=> tx_hw_transfer_service)
		else $error("transfer service request missing");
	bit_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
		(tx_st == tx_shift && !tx_bit_end && !$rose(tx_st == tx_shift)) |=> $stable(tx_pin))
		else $error("line changed inside a bit");
	async_frame_c: cover property (@(posedge clk) disable iff (sys_rst)
		rx_done && cfg.mode == mode_async);
	multi_frame_c: cover property (@(posedge clk) disable iff (sys_rst)
		tx_done && cfg.mode == mode_multi);
	sync_frame_c: cover property (@(posedge clk) disable iff (sys_rst) tx_done && is_sync);
	overrun_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(rx_err.overrun));
endmodule
`default_nettype wire

// ==== dv/uart_peer.sv ====
`default_nettype none
module uart_peer #(
	parameter int bit_clks = 32
) (
	input wire logic clk,
	input wire logic tx_pin,
	input wire logic [3:0] rx_len,
	output logic rx_pin,
	output logic [11:0] got,
	output logic [7:0] n_got
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----
	// line watcher
	// ----
	// sampled on the falling clock so the registered line never races the read
	initial begin
		n_got = 8'h00;
		got = 12'h000;
		forever begin
			@(negedge tx_pin);
			got = 12'h000;
			repeat (bit_clks / 2) @(negedge clk);
			for (int i = 0; i < int'(rx_len); i++) begin
				repeat (bit_clks) @(negedge clk);
				got[i] = tx_pin;
			end
			n_got = n_got + 8'h01;
		end
	end

	// ----
	// line driver
	// ----
	initial begin
		rx_pin = 1'h1;
	end

	// start bit, then n bits lsb first, each held a whole bit; idle high after
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = -1; i < n; i++) begin
			rx_pin = (i < 0) ? 1'h0 : bits[i];
			repeat (bit_clks) @(posedge clk);
			#1;
		end
		rx_pin = 1'h1;
		// let the line idle one clock so a following frame never overwrites it in one step
		@(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// ==== dv/uart_core_tb_top.sv ====
`default_nettype none
module uart_core_tb_top
	import uart_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int bit_clks = 2 * oversample;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	uart_cfg_t cfg = uart_cfg_t'(11'h003);
	logic ext_clk_in = 1'h0;
	logic timer0_out = 1'h0;
	logic rx_pin, tx_pin, sclk_out, sclk_oe, tx_ready, rx_valid, tx_irq, rx_irq, tx_hw, rx_hw;
	logic tx_valid = 1'h0;
	logic rx_read = 1'h0;
	logic err_clear = 1'h0;
	logic hw_en = 1'h0;
	logic [8:0] tx_data = 9'h000;
	logic [8:0] rx_data, d0, d1;
	rx_err_t rx_err;
	logic [3:0] rx_len = 4'ha;
	logic [11:0] got;
	logic [7:0] n_got;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_sclk = 0;
	int n0;
	logic [7:0] sync_got = 8'h00;
	// {mode, seven_bit, parity_en, parity_odd, two_stop}
	logic [5:0] tbl [6] = '{6'h00, 6'h0d, 6'h06, 6'h09, 6'h15, 6'h1d};

	uart_core u_uart_core (
		.clk(clk),
		.sys_rst(sys_rst),
		.cfg(cfg),
		.ext_clk_in(ext_clk_in),
		.timer0_out(timer0_out),
		.rx_pin(rx_pin),
		.tx_pin(tx_pin),
		.serial_clock_pin_out(sclk_out),
		.serial_clock_pin_oe(sclk_oe),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.rx_read(rx_read),
		.rx_err(rx_err),
		.err_clear(err_clear),
		.tx_irq(tx_irq),
		.rx_irq(rx_irq),
		.tx_hw_transfer_service(tx_hw),
		.rx_hw_transfer_service(rx_hw),
		.hw_transfer_service_en(hw_en)
	);

	uart_peer #(.bit_clks(bit_clks)) u_uart_peer (
		.clk(clk),
		.tx_pin(tx_pin),
		.rx_len(rx_len),
		.rx_pin(rx_pin),
		.got(got),
		.n_got(n_got)
	);

	// ----
	// clock, watchdog, reporting
	// ----
	initial begin
		forever #2 clk = ~clk;
	end

	always @(posedge sclk_out) n_sclk <= n_sclk + 1;

	// sync partner: latch the line on each rising shift clock, lsb first
	always @(posedge sclk_out) sync_got <= {tx_pin, sync_got[7:1]};

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch = n_mismatch + 1;
			results();
		end
	end

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----
	// frame model and drivers
	// ----
	// bits after the start bit, lsb first; first stop level given by the caller, any second stop high
	function automatic logic [11:0] frame(input logic [8:0] d, input logic stop, input logic two,
		output int n);
		logic [11:0] f;
		f = 12'h000;
		n = (cfg.mode == mode_async && cfg.seven_bit) ? 7 : 8;
		for (int i = 0; i < n; i++) begin
			f[i] = d[i];
		end
		if (cfg.mode == mode_multi) begin
			f[n] = d[8];
			n++;
		end else if (cfg.parity_en) begin
			f[n] = ^(d[7:0] & (n == 7 ? 8'h7f : 8'hff)) ^ cfg.parity_odd;
			n++;
		end
		f[n] = stop;
		n++;
		if (two) begin
			f[n] = 1'h1;
			n++;
		end
		return f;
	endfunction

	function automatic logic [8:0] dmask();
		return cfg.mode == mode_multi ? 9'h1ff : (cfg.seven_bit ? 9'h07f : 9'h0ff);
	endfunction

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic set_cfg(input logic [5:0] c);
		int n;
		logic [11:0] f;
		cfg = uart_cfg_t'({c, 3'h0, 2'h3});
		f = frame(9'h000, 1'h1, cfg.two_stop, n);
		rx_len = n[3:0];
		hw_en = 1'($urandom);
		step();
	endtask

	task automatic tx_put(input logic [8:0] d);
		tx_data = d;
		tx_valid = 1'h1;
		while (tx_ready !== 1'h1) step();
		step();
		tx_valid = 1'h0;
		step();
	endtask

	task automatic tx_expect(input logic [8:0] d);
		logic [11:0] f;
		int n;
		logic [7:0] g0;
		g0 = n_got;
		f = frame(d, 1'h1, cfg.two_stop, n);
		for (int i = 0; i < 2000 && n_got == g0; i++) step();
		check(got, f);
		for (int i = 0; i < 80 && tx_irq !== 1'h1; i++) step();
		check(tx_irq, 1'h1);
		check(tx_hw, hw_en);
	endtask

	// bad[0] sends a low stop bit, bad[1] inverts the bit before the stop
	task automatic rx_word(input logic [8:0] d, input logic [1:0] bad);
		logic [11:0] f;
		int n;
		f = frame(d, ~bad[0], 1'h0, n);
		f[n - 2] = f[n - 2] ^ bad[1];
		u_uart_peer.send(f, n);
		for (int i = 0; i < 64 && rx_irq !== 1'h1; i++) step();
		check(rx_irq, 1'h1);
	endtask

	task automatic clear_rx();
		rx_read = 1'h1;
		err_clear = 1'h1;
		step();
		rx_read = 1'h0;
		err_clear = 1'h0;
		step();
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(32'hafe40915));
		repeat (20) @(posedge clk);
		check(tx_pin, 1'h1);
		check(tx_ready, 1'h1);
		#1 sys_rst = 1'h0;
		for (int k = 0; k < 6; k++) begin
			set_cfg(tbl[k]);
			check(sclk_oe, 1'h0);
			d0 = 9'($urandom);
			d1 = 9'($urandom);
			tx_put(d0);
			check(tx_irq, 1'h0);
			tx_put(d1);
			check(tx_ready, 1'h0);
			tx_expect(d0);
			fork
				tx_expect(d1);
				rx_word(d0, 2'h0);
			join
			check(rx_data & dmask(), d0 & dmask());
			check(rx_err, 3'h0);
			check(rx_hw, hw_en);
			clear_rx();
			$display("config %0d done", k);
		end
		set_cfg(tbl[1]);
		rx_word(9'h05a, 2'h2);
		check(rx_err, 3'h1);
		clear_rx();
		rx_word(9'h0a5, 2'h1);
		check(rx_err, 3'h4);
		clear_rx();
		check(rx_err, 3'h0);
		set_cfg(tbl[0]);
		d0 = 9'($urandom);
		rx_word(d0, 2'h0);
		rx_word(~d0, 2'h0);
		check(rx_data[7:0], d0[7:0]);
		check(rx_err, 3'h2);
		clear_rx();
		set_cfg(tbl[4]);
		rx_word(9'h1c3, 2'h2);
		check(rx_err, 3'h0);
		check(rx_data, 9'h0c3);
		clear_rx();
		$display("receive errors done");
		set_cfg(6'h20);
		check(sclk_oe, 1'h1);
		n0 = n_sclk;
		d0 = 9'($urandom);
		tx_put(d0);
		repeat (60) step();
		check(12'(n_sclk - n0), 12'h008);
		check(sync_got, d0[7:0]);
		check(rx_data, 9'h0ff);
		clear_rx();
		// timer-driven bit clock: one tick per rising edge of the timer output
		cfg.baud = clk_timer0;
		n0 = n_sclk;
		d1 = 9'($urandom);
		tx_put(d1);
		repeat (40) begin
			timer0_out = ~timer0_out;
			repeat (2) step();
		end
		check(12'(n_sclk - n0), 12'h008);
		check(sync_got, d1[7:0]);
		cfg.baud = clk_ext_pin;
		step();
		check(sclk_oe, 1'h0);
		$display("sync done");
		results();
	end
endmodule
`default_nettype wire
